// ---- ppo_host.sv ----
// Host counter card model: drives the differential start line, times out_p.
// Assumes out_p comes from the block on the same clock.
`timescale 1ns/1ns
`default_nettype none
module ppo_host #(
    parameter int HOLD_CYC = 20000
) (
    input wire logic clk,
    input wire logic out_p,
    output logic start_p,
    output logic start_n,
    output int delay_cyc,
    output int width_cyc,
    output int rises,
    output int falls
);
    int cyc;
    int t0;
    int t1;
    logic sp_q;
    logic op_q;
    initial begin
        start_p = 1'b0;
        start_n = 1'b1;
        {cyc, t0, t1, rises, falls, delay_cyc, width_cyc} = '0;
        {sp_q, op_q} = 2'b00;
    end
    task poll();
        @(posedge clk);
        start_p <= 1'b1;
        start_n <= 1'b0;
        repeat (HOLD_CYC) @(posedge clk);
        start_p <= 1'b0;
        start_n <= 1'b1;
    endtask : poll
    always @(posedge clk) begin
        cyc <= cyc + 1;
        sp_q <= start_p;
        op_q <= out_p;
        if (start_p && !sp_q) begin
            t0 <= cyc;
        end
        if (out_p === 1'b1 && !op_q) begin
            t1 <= cyc;
            delay_cyc <= cyc - t0;
            rises <= rises + 1;
        end
        if (out_p === 1'b0 && op_q) begin
            width_cyc <= cyc - t1;
            falls <= falls + 1;
        end
    end
endmodule : ppo_host
`default_nettype wire

// ---- ppo_output.sv ----
// Position pulse output: start/stop and width-pulse timing, status lights, register file.
// Assumes sense comes from same-clock logic and start pins arrive asynchronously.
`timescale 1ns/1ns
`default_nettype none
module ppo_output
    import ppo_pkg::*;
#(
    parameter int PULSE_CYC_P = PULSE_CYC,
    parameter int NO_POLL_CYC_P = NO_POLL_CYC,
    parameter int TICK_DIV_P = TICK_DIV
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire ppo_sense_t sense,
    input wire logic start_p,
    input wire logic start_n,
    output logic out_p,
    output logic out_n,
    output logic led_green,
    output logic led_red,
    output logic led_yellow,
    output logic irq
);

    localparam ppo_state_t RST_STATE = '{
        fsm: FSM_IDLE,
        mode: ppo_mode_t'(CTRL_MODE_RST),
        enable: CTRL_EN_RST,
        recirc: RECIRC_RST,
        gap: GAP_RST,
        mask: MASK_RST,
        status: 3'h0,
        cnt: 24'h000000,
        hold: 24'h000000,
        poll_cnt: 24'h000000,
        pos_latch: 16'h0000,
        out_level: 1'b0,
        prev_start: 1'b0,
        prev_red: 1'b0,
        prev_nopoll: 1'b0,
        led: 3'h0,
        ack: 1'b0,
        rdata: 32'h00000000
    };

    ppo_state_t s;
    ppo_state_t next_s;
    logic tick;
    logic start_raw;
    logic start_lvl;
    logic start_edge;
    logic red_now;
    logic nopoll_now;
    logic done_ev;
    logic [2:0] ev;
    logic [2:0] clr;
    logic req;

    // Width in ticks, scaled by recirculation
    function automatic logic [23:0] width_ticks(input logic [15:0] pos, input logic [6:0] rec);
        width_ticks = 24'(pos) * 24'(rec);
    endfunction : width_ticks

    function automatic logic [31:0] read_mux(input ppo_state_t st, input logic [7:0] adr);
        read_mux = 32'h00000000;
        case (adr)
            REG_CTRL: begin
                read_mux[CTRL_MODE_LSB +: 2] = st.mode;
                read_mux[CTRL_EN_BIT] = st.enable;
            end
            REG_RECIRC: read_mux[6:0] = st.recirc;
            REG_GAP: read_mux[15:0] = st.gap;
            REG_POSITION: read_mux[15:0] = st.pos_latch;
            REG_STATUS: read_mux[2:0] = st.status;
            REG_MASK: read_mux[2:0] = st.mask;
            REG_LED: begin
                read_mux[LED_GREEN_BIT] = st.led.green;
                read_mux[LED_RED_BIT] = st.led.red;
                read_mux[LED_YELLOW_BIT] = st.led.yellow;
            end
            default: read_mux = 32'h00000000;
        endcase
    endfunction : read_mux

    // Differential start input, qualified then synchronised
    assign start_raw = start_p & ~start_n;

    ppo_sync #(
        .W(1)
    ) u_sync (
        .clk(clk),
        .rst_b(rst_b),
        .pin(start_raw),
        .level(start_lvl)
    );

    ppo_tick #(
        .DIV(TICK_DIV_P)
    ) u_tick (
        .clk(clk),
        .rst_b(rst_b),
        .tick(tick)
    );

    assign start_edge = start_lvl & ~s.prev_start;
    assign req = read | write;
    assign waitrequest = req & ~s.ack;
    assign readdata = s.rdata;
    assign out_p = s.out_level;
    assign out_n = ~s.out_level;
    assign led_green = s.led.green;
    assign led_red = s.led.red;
    assign led_yellow = s.led.yellow;
    assign irq = |(s.status & s.mask);

    // Red for fault or bad magnet
    assign red_now = sense.fault | sense.null_zone | sense.dead_zone | ~sense.magnet_present;
    assign nopoll_now = (s.poll_cnt >= 24'(NO_POLL_CYC_P));

    always_comb begin
        next_s = s;
        done_ev = 1'b0;
        next_s.prev_start = start_lvl;
        next_s.prev_red = red_now;
        next_s.prev_nopoll = nopoll_now;

        next_s.led.red = red_now;
        next_s.led.green = sense.magnet_present & ~red_now;
        next_s.led.yellow = nopoll_now;

        if (start_edge) begin
            next_s.poll_cnt = 24'h000000;
        end else if (!nopoll_now) begin
            next_s.poll_cnt = s.poll_cnt + 24'h000001;
        end

        case (s.fsm)
            FSM_IDLE: begin
                next_s.out_level = 1'b0;
                case (s.mode)
                    start_stop_mode: begin
                        if (start_edge) begin
                            next_s.pos_latch = sense.position;
                            next_s.cnt = 24'(sense.position);
                            next_s.fsm = FSM_DELAY;
                        end
                    end
                    width_pulse_host_polled: begin
                        if (start_edge) begin
                            next_s.pos_latch = sense.position;
                            next_s.cnt = width_ticks(sense.position, s.recirc);
                            next_s.out_level = 1'b1;
                            next_s.fsm = FSM_PULSE;
                        end
                    end
                    width_pulse_self_polled: begin
                        next_s.pos_latch = sense.position;
                        next_s.cnt = width_ticks(sense.position, s.recirc);
                        next_s.out_level = 1'b1;
                        next_s.poll_cnt = 24'h000000;
                        next_s.fsm = FSM_PULSE;
                    end
                    default: begin
                        next_s.fsm = FSM_IDLE;
                    end
                endcase
            end
            FSM_DELAY: begin
                if (s.cnt == 24'h000000) begin
                    // Single stop pulse of 1 ms
                    next_s.out_level = 1'b1;
                    next_s.hold = 24'(PULSE_CYC_P - 1);
                    next_s.fsm = FSM_PULSE;
                end else if (tick) begin
                    next_s.cnt = s.cnt - 24'h000001;
                end
            end
            FSM_PULSE: begin
                if (s.mode == start_stop_mode) begin
                    if (s.hold == 24'h000000) begin
                        next_s.out_level = 1'b0;
                        done_ev = 1'b1;
                        next_s.fsm = FSM_IDLE;
                    end else begin
                        next_s.hold = s.hold - 24'h000001;
                    end
                end else begin
                    if (s.cnt == 24'h000000) begin
                        next_s.out_level = 1'b0;
                        done_ev = 1'b1;
                        next_s.hold = 24'(s.gap);
                        next_s.fsm = (s.mode == width_pulse_self_polled) ? FSM_GAP : FSM_IDLE;
                    end else if (tick) begin
                        next_s.cnt = s.cnt - 24'h000001;
                    end
                end
            end
            FSM_GAP: begin
                next_s.out_level = 1'b0;
                if (s.hold == 24'h000000) begin
                    next_s.fsm = FSM_IDLE;
                end else begin
                    next_s.hold = s.hold - 24'h000001;
                end
            end
            default: begin
                next_s.out_level = 1'b0;
                next_s.fsm = FSM_IDLE;
            end
        endcase

        // Disabled output stays low and idle
        if (!s.enable) begin
            next_s.out_level = 1'b0;
            next_s.fsm = FSM_IDLE;
        end

        // Bus: capture on first edge, commit on second
        clr = 3'h0;
        if (req && !s.ack) begin
            next_s.ack = 1'b1;
            next_s.rdata = read ? read_mux(s, address) : 32'h00000000;
        end else begin
            next_s.ack = 1'b0;
        end
        if (req && s.ack) begin
            if (write) begin
                case (address)
                    REG_CTRL: begin
                        next_s.mode = ppo_mode_t'(writedata[CTRL_MODE_LSB +: 2]);
                        next_s.enable = writedata[CTRL_EN_BIT];
                        next_s.fsm = FSM_IDLE;
                        next_s.out_level = 1'b0;
                    end
                    REG_RECIRC: begin
                        next_s.recirc = (writedata[6:0] == 7'h00) ? RECIRC_RST : writedata[6:0];
                    end
                    REG_GAP: next_s.gap = writedata[15:0];
                    REG_MASK: next_s.mask = writedata[2:0];
                    default: next_s.ack = 1'b0;
                endcase
            end else if (address == REG_STATUS) begin
                clr = s.rdata[2:0];
            end
        end

        // Sticky events; set wins over read clear
        ev = 3'h0;
        ev[ST_DONE_BIT] = done_ev;
        ev[ST_FAULT_BIT] = red_now & ~s.prev_red;
        ev[ST_NOPOLL_BIT] = nopoll_now & ~s.prev_nopoll;
        next_s.status = (s.status & ~clr) | ev;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s <= RST_STATE;
        end else begin
            s <= next_s;
        end
    end

endmodule : ppo_output
`default_nettype wire

// ---- ppo_output_properties.sv ----
// Concurrent checks on the position pulse output ports.
// Bound into ppo_output; CTRL and RECIRC are shadowed from bus writes.
`timescale 1ns/1ns
`default_nettype none
module ppo_output_properties
    import ppo_pkg::*;
#(
    parameter int PULSE_CYC_P = PULSE_CYC,
    parameter int NO_POLL_CYC_P = NO_POLL_CYC,
    parameter int TICK_DIV_P = TICK_DIV
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    input wire ppo_sense_t sense,
    input wire logic start_p,
    input wire logic start_n,
    input wire logic out_p,
    input wire logic out_n,
    input wire logic led_green,
    input wire logic led_red,
    input wire logic led_yellow,
    input wire logic irq
);
    logic [1:0] mode_sh;
    logic en_sh;
    logic [6:0] rec_sh;
    logic [23:0] hi_cnt;
    logic [23:0] exp_w;
    logic wr_ok;
    assign wr_ok = write && !waitrequest;
    assign exp_w = 24'(sense.position) * 24'(rec_sh) + 24'h1;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mode_sh <= CTRL_MODE_RST;
            en_sh <= CTRL_EN_RST;
            rec_sh <= RECIRC_RST;
            hi_cnt <= 24'h0;
        end else begin
            hi_cnt <= out_p ? hi_cnt + 24'h1 : 24'h0;
            if (wr_ok && address == REG_CTRL) begin
                mode_sh <= writedata[1:0];
                en_sh <= writedata[2];
            end
            if (wr_ok && address == REG_RECIRC) begin
                rec_sh <= (writedata[6:0] == 7'h00) ? 7'h01 : writedata[6:0];
            end
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence start_edge_s;
        mode_sh == width_pulse_host_polled && en_sh && !out_p && $rose(start_p && !start_n);
    endsequence
    sequence pulse_rise_s;
        ##[2:6] $rose(out_p);
    endsequence
    out_pair_a: assert property (out_n == !out_p)
        else $error("out_n not complement of out_p");
    stop_width_a: assert property ($fell(out_p) && mode_sh == start_stop_mode && $stable(mode_sh)
        |-> hi_cnt == PULSE_CYC_P) else $error("stop pulse width wrong");
    width_scale_a: assert property ($fell(out_p) && mode_sh[1] && $stable(mode_sh)
        |-> hi_cnt == exp_w) else $error("width pulse not scaled to position");
    poll_start_a: assert property (start_edge_s |-> pulse_rise_s)
        else $error("host-polled pulse late");
    cp_idle_a: assert property ((mode_sh == control_pulse_mode || !en_sh) && $stable(mode_sh)
        && $stable(en_sh) |-> !out_p) else $error("output active while idle mode");
    red_light_a: assert property ($past(rst_b) |-> led_red ==
        $past(sense.fault || sense.null_zone || sense.dead_zone || !sense.magnet_present)) else $error("red wrong");
    green_light_a: assert property ($past(rst_b) && !$past(sense.magnet_present) |-> !led_green)
        else $error("green without magnet");
    bus_wait_a: assert property ((read || write) && waitrequest |=> !waitrequest)
        else $error("no answer after one wait state");
    unmapped_read_a: assert property (read && !waitrequest && address > REG_LED |-> readdata == 32'h0)
        else $error("unmapped read not zero");
endmodule : ppo_output_properties
bind ppo_output ppo_output_properties #(.PULSE_CYC_P(PULSE_CYC_P), .NO_POLL_CYC_P(NO_POLL_CYC_P),
    .TICK_DIV_P(TICK_DIV_P)) u_props (.clk(clk), .rst_b(rst_b), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .sense(sense),
    .start_p(start_p), .start_n(start_n), .out_p(out_p), .out_n(out_n), .led_green(led_green),
    .led_red(led_red), .led_yellow(led_yellow), .irq(irq));
`default_nettype wire

// ---- ppo_output_test.sv ----
// Self-checking bench for the position pulse output block.
// Host model drives the start pins; registers are reached over Avalon-MM.
`timescale 1ns/1ns
`default_nettype none
module ppo_output_test
    import ppo_pkg::*;
;
    localparam int PC = 8;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] address = 8'h00;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0;
    // Position 5, magnet present, no faults
    ppo_sense_t sense = 20'h00058;
    logic [31:0] readdata, rd;
    logic waitrequest, start_p, start_n, out_p, out_n, led_green, led_red, led_yellow, irq;
    int delay_cyc, width_cyc, rises, falls, d1, i, r;
    int fails = 0;
    int checks_done = 0;
    int hp_pos[3] = '{0, 3, 4};
    int hp_rec[3] = '{1, 1, 3};
    logic [3:0] flags[5] = '{4'hC, 4'hA, 4'h9, 4'h0, 4'h8};
    ppo_output #(.PULSE_CYC_P(PC), .NO_POLL_CYC_P(50), .TICK_DIV_P(1)) dut (.clk(clk), .rst_b(rst_b),
        .address(address), .read(read), .write(write), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .sense(sense), .start_p(start_p), .start_n(start_n), .out_p(out_p),
        .out_n(out_n), .led_green(led_green), .led_red(led_red), .led_yellow(led_yellow), .irq(irq));
    ppo_host #(.HOLD_CYC(10)) host (.clk(clk), .out_p(out_p), .start_p(start_p), .start_n(start_n),
        .delay_cyc(delay_cyc), .width_cyc(width_cyc), .rises(rises), .falls(falls));
    initial begin
        forever #25 clk = ~clk;
    end
    task end_of_test();
        $display("checks %0d, mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_of_test
    task chk(input logic [31:0] got, input logic [31:0] want);
        checks_done++;
        if (got !== want) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, want);
        end
    endtask : chk
    task bus_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        address <= a;
        writedata <= d;
        write <= 1'b1;
        @(posedge clk);
        while (waitrequest !== 1'b0) @(posedge clk);
        write <= 1'b0;
    endtask : bus_write
    task bus_read(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        address <= a;
        read <= 1'b1;
        @(posedge clk);
        while (waitrequest !== 1'b0) @(posedge clk);
        d = readdata;
        read <= 1'b0;
    endtask : bus_read
    task rd_chk(input logic [7:0] a, input logic [31:0] want);
        bus_read(a, rd);
        chk(rd, want);
    endtask : rd_chk
    task pulse(input logic [15:0] pos);
        int n;
        int k;
        @(posedge clk);
        sense.position <= pos;
        n = falls;
        k = rises;
        host.poll();
        for (int j = 0; j < 400 && falls == n; j++) @(negedge clk);
        repeat (10) @(negedge clk);
        chk(32'(rises - k), 32'h1);
    endtask : pulse
    initial begin
        repeat (5000) @(posedge clk);
        fails++;
        end_of_test();
    end
    initial begin
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        rd_chk(REG_LED, 32'h1);
        rd_chk(REG_CTRL, 32'h5);
        rd_chk(REG_RECIRC, 32'h1);
        rd_chk(REG_GAP, 32'h3E8);
        rd_chk(REG_MASK, 32'h0);
        rd_chk(8'h1C, 32'h0);
        bus_write(REG_LED, 32'h6);
        rd_chk(REG_LED, 32'h1);
        bus_write(REG_RECIRC, 32'h0);
        rd_chk(REG_RECIRC, 32'h1);
        bus_write(REG_RECIRC, 32'h7F);
        rd_chk(REG_RECIRC, 32'h7F);
        bus_write(REG_RECIRC, 32'h1);
        pulse(16'h5);
        chk(32'(width_cyc), 32'(PC));
        chk(32'(led_yellow), 32'h0);
        d1 = delay_cyc;
        pulse(16'h14);
        chk(32'(32'(delay_cyc - d1 - 14) <= 32'h2), 32'h1);
        rd_chk(REG_POSITION, 32'h14);
        bus_write(REG_MASK, 32'h1);
        bus_write(REG_CTRL, 32'h6);
        bus_read(REG_STATUS, rd);
        for (i = 0; i < 3; i++) begin
            bus_write(REG_RECIRC, 32'(hp_rec[i]));
            pulse(16'(hp_pos[i]));
            chk(32'(width_cyc), 32'(hp_pos[i] * hp_rec[i] + 1));
            chk(32'(delay_cyc <= 6), 32'h1);
            chk(32'(irq), 32'h1);
            bus_read(REG_STATUS, rd);
            chk(rd & 32'h1, 32'h1);
            repeat (2) @(negedge clk);
            chk(32'(irq), 32'h0);
        end
        bus_write(REG_MASK, 32'h0);
        pulse(16'h2);
        chk(32'(irq), 32'h0);
        bus_write(REG_RECIRC, 32'h1);
        bus_write(REG_GAP, 32'h4);
        bus_write(REG_CTRL, 32'h7);
        repeat (20) @(negedge clk);
        r = rises;
        repeat (90) @(negedge clk);
        chk(32'(rises - r), 32'hA);
        chk(32'(width_cyc), 32'h3);
        bus_write(REG_CTRL, 32'h4);
        r = rises;
        host.poll();
        repeat (20) @(negedge clk);
        chk(32'(rises - r), 32'h0);
        bus_write(REG_CTRL, 32'h1);
        r = rises;
        host.poll();
        repeat (60) @(negedge clk);
        chk(32'(rises - r), 32'h0);
        chk(32'(led_yellow), 32'h1);
        for (i = 0; i < 5; i++) begin
            @(posedge clk);
            sense[3:0] <= flags[i];
            repeat (3) @(negedge clk);
            chk(32'(led_red), 32'(flags[i] != 4'h8));
            if (flags[i] == 4'h0 || flags[i] == 4'h8) chk(32'(led_green), 32'(flags[i][3]));
        end
        rd_chk(REG_STATUS, 32'h7);
        rd_chk(REG_STATUS, 32'h0);
        end_of_test();
    end
endmodule : ppo_output_test
`default_nettype wire

// ---- ppo_pkg.sv ----
// Constants, register map and carrier types of the position pulse output block.
// Assumes a single 20 MHz clock and a word-aligned Avalon-MM register bus.
package ppo_pkg;

    localparam int CLK_HZ = 20_000_000;
    localparam int PULSE_MS = 1;
    localparam int PULSE_CYC = (CLK_HZ / 1000) * PULSE_MS;
    localparam int OUT_DELAY_NS = 50;
    localparam int OUT_DELAY_CYC = (OUT_DELAY_NS * (CLK_HZ / 1_000_000)) / 1000 < 1 ? 1 :
                                   (OUT_DELAY_NS * (CLK_HZ / 1_000_000)) / 1000;
    localparam int NO_POLL_MS = 100;
    localparam int NO_POLL_CYC = (CLK_HZ / 1000) * NO_POLL_MS;
    localparam int TICK_DIV = 1;

    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_RECIRC = 8'h04;
    localparam logic [7:0] REG_GAP = 8'h08;
    localparam logic [7:0] REG_POSITION = 8'h0C;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam logic [7:0] REG_MASK = 8'h14;
    localparam logic [7:0] REG_LED = 8'h18;

    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_EN_BIT = 2;
    localparam int ST_DONE_BIT = 0;
    localparam int ST_FAULT_BIT = 1;
    localparam int ST_NOPOLL_BIT = 2;
    localparam int LED_GREEN_BIT = 0;
    localparam int LED_RED_BIT = 1;
    localparam int LED_YELLOW_BIT = 2;

    localparam logic [1:0] CTRL_MODE_RST = 2'h1;
    localparam logic CTRL_EN_RST = 1'b1;
    localparam logic [6:0] RECIRC_RST = 7'h01;
    localparam logic [15:0] GAP_RST = 16'h03E8;
    localparam logic [2:0] MASK_RST = 3'h0;

    typedef enum logic [1:0] {
        control_pulse_mode = 2'h0,
        start_stop_mode = 2'h1,
        width_pulse_host_polled = 2'h2,
        width_pulse_self_polled = 2'h3
    } ppo_mode_t;

    typedef enum logic [3:0] {
        FSM_IDLE = 4'b0001,
        FSM_DELAY = 4'b0010,
        FSM_PULSE = 4'b0100,
        FSM_GAP = 4'b1000
    } ppo_fsm_t;

    typedef struct packed {
        logic [15:0] position;
        logic magnet_present;
        logic fault;
        logic null_zone;
        logic dead_zone;
    } ppo_sense_t;

    typedef struct packed {
        logic green;
        logic red;
        logic yellow;
    } ppo_led_t;

    typedef struct packed {
        ppo_fsm_t fsm;
        ppo_mode_t mode;
        logic enable;
        logic [6:0] recirc;
        logic [15:0] gap;
        logic [2:0] mask;
        logic [2:0] status;
        logic [23:0] cnt;
        logic [23:0] hold;
        logic [23:0] poll_cnt;
        logic [15:0] pos_latch;
        logic out_level;
        logic prev_start;
        logic prev_red;
        logic prev_nopoll;
        ppo_led_t led;
        logic ack;
        logic [31:0] rdata;
    } ppo_state_t;

endpackage : ppo_pkg

// ---- ppo_sync.sv ----
// Three-stage synchroniser for pin inputs.
// Output changes only once the second and third stages agree.
`timescale 1ns/1ns
`default_nettype none
module ppo_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [W-1:0] pin,
    output logic [W-1:0] level
);
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
            level <= '0;
        end else begin
            s1 <= pin;
            s2 <= s1;
            s3 <= s2;
            for (int i = 0; i < W; i++) begin
                if (s2[i] == s3[i]) begin
                    level[i] <= s2[i];
                end
            end
        end
    end
endmodule : ppo_sync
`default_nettype wire

// ---- ppo_tick.sv ----
// Divider giving a one-cycle position tick enable.
// One tick stands for one position count on the output timing.
`timescale 1ns/1ns
`default_nettype none
module ppo_tick #(
    parameter int DIV = 1
) (
    input wire logic clk,
    input wire logic rst_b,
    output logic tick
);
    logic [15:0] cnt;

    assign tick = (cnt == 16'(DIV - 1));

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt <= 16'h0000;
        end else if (tick) begin
            cnt <= 16'h0000;
        end else begin
            cnt <= cnt + 16'h0001;
        end
    end
endmodule : ppo_tick
`default_nettype wire
